//--- port_pin_function_mapper_test.sv
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_mapper_test;
    `define CHECK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
        $display("ERROR %s expected %0h seen %0h", n, e, s); end end
    // ========================================
    // signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] aw = 12'h000, ar = 12'h000;
    logic awv = 1'b0, arv = 1'b0, inv = 1'b0;
    logic [31:0] wd = 32'h0, pat = 32'h0, got, rdt;
    logic [5:0] code = 6'h00;
    logic [17:0] pi = 18'h3ffff, po, poe, pan;
    logic [1:0] rrs, gresp, brs;
    logic awr, bv, arr, rv, irq;
    logic [32:0] rpi;
    logic [31:0] rpo, rpoe;
    logic [29:1] per;
    logic [36:0] pin;
    int fail_count = 0, cmp_count = 0;
    always #5 aclk = ~aclk;
    // small variant, so the absent-port masking is exercised
    ppfm_top #(.PKG_PINS(ppfm_pkg::PINS_SMALL)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(awv),
        .s_axi_wready(), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .port_pin_i(pi),
        .port_pin_o(po), .port_pin_oe_n(poe), .port_analog_en(pan), .rp_pin_i(rpi),
        .rp_pin_o(rpo), .rp_pin_oe_n(rpoe), .periph_out(per), .periph_in(pin), .irq(irq));
    ppfm_periph_model far (.aclk(aclk), .code(code), .inv(inv), .pat(pat),
        .periph_out(per), .rp_pin_i(rpi));
    // ========================================
    // bus tasks; ready lines stay high, so answers are taken at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        do @(posedge aclk); while (!awr);
        awv <= 1'b0;
        while (!bv) @(posedge aclk);
        gresp = brs;
    endtask
    task automatic rd(input logic [11:0] a);
        ar <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        got = rdt;
        gresp = rrs;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset;
        `CHECK("rp_oe_n", 32'hffffffff, rpoe)
        rd(ppfm_pkg::OFF_OUT_SEL);
        `CHECK("out_sel", 32'h0, got)
        rd(ppfm_pkg::OFF_IN_SEL);
        `CHECK("in_sel", 32'h3f3f, got)
        rd(12'hffc);
        `CHECK("unmapped resp", ppfm_pkg::RESP_SLVERR, gresp)
        wr(12'hffc, 32'h0);
        `CHECK("unmapped wr resp", ppfm_pkg::RESP_SLVERR, gresp)
        $display("t_reset done");
    endtask
    task automatic t_outputs;
        // codes 0 to 31, both polarities, both fields of one register
        for (int c = 0; c < 32; c++) begin
            code <= c[5:0];
            wr(ppfm_pkg::OFF_OUT_SEL, {18'h0, c[5:0], 2'h0, c[5:0]});
            for (int v = 0; v < 2; v++) begin
                inv <= v[0];
                repeat (3) @(posedge aclk);
                `CHECK("rp_o", (c > 0 && c < 30) ? {2{~v[0]}} : 2'h0, rpo[1:0])
                `CHECK("rp_oe_n", (c > 0 && c < 30) ? 2'h0 : 2'h3, rpoe[1:0])
            end
        end
        `CHECK("irq masked", 1'b0, irq)
        wr(ppfm_pkg::OFF_IRQ_MASK, 32'h2);
        `CHECK("irq bad code", 1'b1, irq)
        wr(ppfm_pkg::OFF_IRQ_STAT, 32'h3);
        `CHECK("irq cleared", 1'b0, irq)
        $display("t_outputs done");
    endtask
    task automatic t_inputs;
        pat <= 32'h21;
        wr(ppfm_pkg::OFF_IN_SEL, 32'h2005);
        repeat (8) @(posedge aclk);
        `CHECK("in pins 5 32", 2'h3, pin[1:0])
        pat <= 32'hffffffff;
        wr(ppfm_pkg::OFF_IN_SEL, 32'h2030);
        repeat (8) @(posedge aclk);
        `CHECK("missing pin", 2'h2, pin[1:0])
        $display("t_inputs done");
    endtask
    task automatic t_ports;
        // analog reset state hides the high pins
        rd(ppfm_pkg::OFF_PORT_IN);
        `CHECK("analog read", 32'h0, got)
        `CHECK("analog_en", 18'h3ffff, pan)
        wr(ppfm_pkg::OFF_ANALOG_SEL, 32'h0);
        repeat (2) @(posedge aclk);
        rd(ppfm_pkg::OFF_PORT_IN);
        `CHECK("digital read", 32'h3ffff, got)
        `CHECK("digital en", 18'h0, pan)
        // port a moves too, but it is absent on the small variant
        pi <= 18'h3fffa;
        repeat (8) @(posedge aclk);
        rd(ppfm_pkg::OFF_CHANGE_STAT);
        `CHECK("port b flag", 32'h2, got)
        wr(ppfm_pkg::OFF_PIN_CHANGE, 32'hc);
        rd(ppfm_pkg::OFF_CHANGE_STAT);
        `CHECK("flag cleared", 32'h0, got)
        wr(ppfm_pkg::OFF_PIN_DIR, 32'h0);
        `CHECK("drive on", 18'h0, poe)
        wr(ppfm_pkg::OFF_PORT_LATCH, 32'h2a5a5);
        `CHECK("latch out", 18'h2a5a5, po)
        $display("t_ports done");
    endtask
    task automatic t_rereset;
        // map two pins, then reset in mid-run: the null code must return
        wr(ppfm_pkg::OFF_OUT_SEL, 32'h0303);
        `CHECK("mapped wr resp", ppfm_pkg::RESP_OKAY, gresp)
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHECK("rp_oe_n again", 32'hffffffff, rpoe)
        rd(ppfm_pkg::OFF_OUT_SEL);
        `CHECK("out_sel again", 32'h0, got)
        $display("t_rereset done");
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        t_reset();
        t_outputs();
        t_inputs();
        t_ports();
        t_rereset();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end
endmodule // port_pin_function_mapper_test
`default_nettype wire

//--- ppfm_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// peripherals and remappable pins
module ppfm_periph_model (
    // clock
    input wire logic aclk,
    // bench controls
    input wire logic [5:0] code,
    input wire logic inv,
    input wire logic [31:0] pat,
    // toward the block
    output logic [29:1] periph_out,
    output logic [32:0] rp_pin_i
);
    // only the output named by code differs, so a wrong pick shows at the pin
    always_ff @(posedge aclk) begin
        for (int i = 1; i <= 29; i++)
            periph_out[i] <= inv ^ (i == int'(code));
        rp_pin_i <= {pat[0], pat}; // input-only pin follows pin 0
    end
endmodule // ppfm_periph_model
`default_nettype wire

//--- ppfm_pkg.sv
`default_nettype none
package ppfm_pkg;

    // ========================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_ANALOG_SEL = 12'h000;
    localparam logic [11:0] OFF_PIN_DIR = 12'h004;
    localparam logic [11:0] OFF_PORT_LATCH = 12'h008;
    localparam logic [11:0] OFF_PORT_IN = 12'h00c;
    localparam logic [11:0] OFF_PIN_CHANGE = 12'h010;
    localparam logic [11:0] OFF_CHANGE_STAT = 12'h014;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01c;
    localparam logic [11:0] OFF_IN_SEL = 12'h040;
    localparam logic [11:0] OFF_OUT_SEL = 12'h100;

    // ========================================
    // field layout
    localparam int SEL_W = 6;
    localparam int FLD_LO = 0;
    localparam int FLD_HI = 8;
    localparam int PORT_COUNT = 9;
    localparam int IRQ_W = 2;
    localparam int IRQ_CHANGE = 0;
    localparam int IRQ_BAD_CODE = 1;

    // ========================================
    // reset values and counts
    localparam logic ANALOG_SEL_RST = 1'h1;
    localparam logic PIN_DIR_RST = 1'h1;
    localparam logic [5:0] IN_SEL_RST = 6'h3f;
    localparam logic [5:0] OUT_SEL_RST = 6'h00;
    localparam int SYNC_PRIME = 4;

    // ========================================
    // ports present per package variant, port a at bit 0
    localparam int PINS_SMALL = 64;
    localparam int PINS_MID = 100;
    localparam logic [8:0] PRESENT_SMALL = 9'h07e;
    localparam logic [8:0] PRESENT_MID = 9'h07f;
    localparam logic [8:0] PRESENT_ALL = 9'h1ff;

    // ========================================
    // output-select codes
    typedef enum logic [5:0] {
        OC_NULL = 6'h00,
        OC_COMPARATOR1 = 6'h01,
        OC_COMPARATOR2 = 6'h02,
        OC_UART1_TX = 6'h03,
        OC_UART1_RTS = 6'h04,
        OC_UART2_TX = 6'h05,
        OC_UART2_RTS = 6'h06,
        OC_SERIAL1_DATA = 6'h07,
        OC_SERIAL1_CLOCK = 6'h08,
        OC_SERIAL1_SELECT = 6'h09,
        OC_SERIAL2_DATA = 6'h0a,
        OC_SERIAL2_CLOCK = 6'h0b,
        OC_SERIAL2_SELECT = 6'h0c,
        OC_COMPARE1 = 6'h0d,
        OC_COMPARE2 = 6'h0e,
        OC_COMPARE3 = 6'h0f,
        OC_SINGLE_CCP4 = 6'h10,
        OC_SINGLE_CCP5 = 6'h11,
        OC_SINGLE_CCP6 = 6'h12,
        OC_UART3_TX = 6'h13,
        OC_UART3_RTS = 6'h14,
        OC_UART4_TX = 6'h15,
        OC_UART4_RTS = 6'h16,
        OC_SERIAL3_DATA = 6'h17,
        OC_SERIAL3_CLOCK = 6'h18,
        OC_SERIAL3_SELECT = 6'h19,
        OC_COMPARATOR3 = 6'h1a,
        OC_SINGLE_CCP7 = 6'h1b,
        OC_REF_CLOCK = 6'h1c,
        OC_LOGIC_CELL1 = 6'h1d
    } ppfm_out_code_t;

    localparam int OUT_CODES = int'(OC_LOGIC_CELL1);

endpackage
`default_nettype wire

//--- ppfm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppfm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin levels
    ppfm_sync_if.sync s
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] st_reg;
    logic [ppfm_pkg::SYNC_PRIME-1:0] prime_reg;
    logic [W-1:0] agree;

    // ========================================
    // three-stage chain; stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= s.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a level counts only once stages two and three agree
    assign agree = ~(s2_reg ^ s3_reg);
    always_ff @(posedge clk) begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= (agree & s3_reg) | (~agree & st_reg);
    end

    // no change pulses until the chain holds real pin data,
    // so pins already high at reset do not raise flags
    always_ff @(posedge clk) begin
        if (!rst_n)
            prime_reg <= '0;
        else
            prime_reg <= {prime_reg[ppfm_pkg::SYNC_PRIME-2:0], 1'b1};
    end

    assign s.stable = st_reg;
    assign s.chg = agree & (s3_reg ^ st_reg) & {W{prime_reg[ppfm_pkg::SYNC_PRIME-1]}};

endmodule // ppfm_sync
`default_nettype wire

//--- ppfm_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// raw pin levels in, settled levels and change pulses out
interface ppfm_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] stable;
    logic [W-1:0] chg;
    modport sync (input raw, output stable, output chg);
    modport user (output raw, input stable, input chg);
endinterface
`default_nettype wire

//--- ppfm_top.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Overview of operation
// R01: each analog-capable pin has one select bit; set means analog, clear digital
// R02: port input reads return low for pins configured as analog inputs
// R03: software keeps select and direction both at one for analog use
// R04: digital input is select 0, direction 1; read valid a cycle later
// R05: digital output is select 0, direction 0; analog output disabled first
// R06: read-only change status holds one hardware-set flag per port a..j
// R07: port flag reads zero until change, clears once all pin changes cleared
// R08: flags j and h absent on small and mid variants, a absent on small
// R09: each remappable input has a six-bit pin field at bits 5:0 or 13:8
// R10: inputs: ccp clocks, logic cell ins, irqs 1-4, captures, faults, triggers
// R11: inputs also: timer clocks 2-5, three serial ports, four uart rx and cts
// R12: output select per pin, two six-bit fields a register, code picks output
// R13: code zero leaves pin undriven; codes 1 to 29 pick one output each
// R14: serial codes: uarts 3-6 and 19-22, serial ports 7-12 and 23-25
// R15: comparators 1,2,26; compares 13-15; ccp 16-18,27; refclk 28; cell 29
// R16: every output-select field holds the null code after reset
// R17: unimplemented output codes behave as the null code
// R18: input selecting a missing pin gets a constant inactive level
module ppfm_top #(
    parameter int PORT_W = 2,
    parameter int NRP = 32,
    parameter int NRPI = 1,
    parameter int NIN = 37,
    parameter int PKG_PINS = 128,
    parameter logic [NIN-1:0] IDLE_LVL = '0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [ppfm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ppfm_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [ppfm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ppfm_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // general-purpose port pins
    input wire logic [ppfm_pkg::PORT_COUNT*PORT_W-1:0] port_pin_i,
    output logic [ppfm_pkg::PORT_COUNT*PORT_W-1:0] port_pin_o,
    output logic [ppfm_pkg::PORT_COUNT*PORT_W-1:0] port_pin_oe_n,
    output logic [ppfm_pkg::PORT_COUNT*PORT_W-1:0] port_analog_en,
    // remappable pins, input-only pins on the top indices
    input wire logic [NRP+NRPI-1:0] rp_pin_i,
    output logic [NRP-1:0] rp_pin_o,
    output logic [NRP-1:0] rp_pin_oe_n,
    // peripheral side of the crossbar
    input wire logic [ppfm_pkg::OUT_CODES:1] periph_out,
    output logic [NIN-1:0] periph_in,
    // interrupt
    output logic irq
);
    localparam int NPP = ppfm_pkg::PORT_COUNT * PORT_W;
    localparam int NPI = NRP + NRPI;
    localparam int NINR = (NIN + 1) / 2;
    localparam int NOR = NRP / 2;
    localparam logic [8:0] PRESENT = (PKG_PINS == ppfm_pkg::PINS_SMALL) ?
        ppfm_pkg::PRESENT_SMALL : (PKG_PINS == ppfm_pkg::PINS_MID) ?
        ppfm_pkg::PRESENT_MID : ppfm_pkg::PRESENT_ALL;

    logic [NPP-1:0] ans_reg;
    logic [NPP-1:0] dir_reg;
    logic [NPP-1:0] lat_reg;
    logic [NPP-1:0] pchg_reg;
    logic [ppfm_pkg::IRQ_W-1:0] ist_reg;
    logic [ppfm_pkg::IRQ_W-1:0] imsk_reg;
    logic [ppfm_pkg::IRQ_W-1:0] ev;
    logic [ppfm_pkg::SEL_W-1:0] insel_reg [NIN];
    logic [ppfm_pkg::SEL_W-1:0] outsel_reg [NRP];
    logic [NPP-1:0] pin_present;
    logic [NPP-1:0] port_st;
    logic [NPP-1:0] port_chg;
    logic [NPI-1:0] rp_st;
    logic [8:0] chg_stat;
    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic hit_ans, hit_dir, hit_lat, hit_pchg, hit_ist, hit_imsk, hit_ro;
    logic [NINR-1:0] hit_in;
    logic [NOR-1:0] hit_out;
    logic bad_code;
    logic wr_mapped;
    logic [31:0] rd_val;
    logic rd_ok;

    function automatic logic code_bad(input logic [5:0] c);
        return c > 6'(ppfm_pkg::OUT_CODES);
    endfunction

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ========================================
    // pin synchronisers
    ppfm_sync_if #(.W(NPP + NPI)) sif ();
    assign sif.raw = {rp_pin_i, port_pin_i};
    ppfm_sync #(.W(NPP + NPI)) u_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .s(sif.sync)
    );
    assign port_st = sif.stable[NPP-1:0];
    assign port_chg = sif.chg[NPP-1:0];
    assign rp_st = sif.stable[NPP+NPI-1:NPP];

    // per-port flag is the or of its pin flags; absent ports stay clear
    for (genvar p = 0; p < ppfm_pkg::PORT_COUNT; p++) begin : g_port
        assign pin_present[p*PORT_W +: PORT_W] = {PORT_W{PRESENT[p]}}; // R08
        assign chg_stat[p] = |pchg_reg[p*PORT_W +: PORT_W]; // R06 R07
    end

    // ========================================
    // write decode: address and data taken together
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wdat = s_axi_wdata & wmask;
    assign hit_ans = wr_go && s_axi_awaddr == ppfm_pkg::OFF_ANALOG_SEL;
    assign hit_dir = wr_go && s_axi_awaddr == ppfm_pkg::OFF_PIN_DIR;
    assign hit_lat = wr_go && s_axi_awaddr == ppfm_pkg::OFF_PORT_LATCH;
    assign hit_pchg = wr_go && s_axi_awaddr == ppfm_pkg::OFF_PIN_CHANGE;
    assign hit_ist = wr_go && s_axi_awaddr == ppfm_pkg::OFF_IRQ_STAT;
    assign hit_imsk = wr_go && s_axi_awaddr == ppfm_pkg::OFF_IRQ_MASK;
    // writes to read-only registers are accepted and dropped
    assign hit_ro = wr_go && (s_axi_awaddr == ppfm_pkg::OFF_PORT_IN ||
                              s_axi_awaddr == ppfm_pkg::OFF_CHANGE_STAT);

    // select banks; a code past the last output is flagged on write
    always_comb begin
        hit_in = '0;
        hit_out = '0;
        bad_code = 1'b0;
        for (int k = 0; k < NINR; k++) begin
            hit_in[k] = wr_go && s_axi_awaddr == ppfm_pkg::OFF_IN_SEL + 12'(4 * k);
        end
        for (int k = 0; k < NOR; k++) begin
            hit_out[k] = wr_go && s_axi_awaddr == ppfm_pkg::OFF_OUT_SEL + 12'(4 * k);
            if (hit_out[k] && ((s_axi_wstrb[0] && code_bad(s_axi_wdata[5:0])) ||
                    (s_axi_wstrb[1] && code_bad(s_axi_wdata[13:8]))))
                bad_code = 1'b1;
        end
    end
    assign wr_mapped = hit_ans | hit_dir | hit_lat | hit_pchg | hit_ist |
                       hit_imsk | hit_ro | (|hit_in) | (|hit_out);

    // write response one cycle after the handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ppfm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? ppfm_pkg::RESP_OKAY : ppfm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    // ========================================
    // pin mode registers: analog select, direction, latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ans_reg <= {NPP{ppfm_pkg::ANALOG_SEL_RST}};
            dir_reg <= {NPP{ppfm_pkg::PIN_DIR_RST}};
            lat_reg <= '0;
        end else begin
            if (hit_ans)
                ans_reg <= (ans_reg & ~wmask[NPP-1:0]) | wdat[NPP-1:0]; // R01
            if (hit_dir)
                dir_reg <= (dir_reg & ~wmask[NPP-1:0]) | wdat[NPP-1:0];
            if (hit_lat)
                lat_reg <= (lat_reg & ~wmask[NPP-1:0]) | wdat[NPP-1:0];
        end
    end

    // an analog pin is never driven digitally; only select 0 with
    // direction 0 drives, the analog path is the user's concern
    assign port_analog_en = ans_reg; // R01
    assign port_pin_oe_n = ans_reg | dir_reg; // R05
    assign port_pin_o = lat_reg;

    analog_no_drive_a: assert property ((port_analog_en & ~port_pin_oe_n) == '0) // R01
        else $error("analog pin has digital drive");

    // ========================================
    // pin change flags, write one to clear; a new change wins
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pchg_reg <= '0;
        else
            pchg_reg <= (pchg_reg & ~(hit_pchg ? wdat[NPP-1:0] : '0)) |
                        (port_chg & pin_present); // R06 R07
    end

    chg_sets_flag_a: assert property (port_chg[2] && pin_present[2] |=> pchg_reg[2]) // R06
        else $error("detected change not flagged");
    port_flag_clear_a: assert property (hit_pchg && (&wdat[3:2]) && port_chg[3:2] == '0
        |=> !chg_stat[1]) // R07
        else $error("port flag stuck after all pins cleared");
    absent_port_a: assert property ((chg_stat & ~PRESENT) == '0) // R08
        else $error("flag set for absent port");

    // ========================================
    // interrupt status, write one to clear; set wins over clear
    assign ev[ppfm_pkg::IRQ_CHANGE] = |(port_chg & pin_present);
    assign ev[ppfm_pkg::IRQ_BAD_CODE] = bad_code;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_reg <= '0;
            imsk_reg <= '0;
        end else begin
            ist_reg <= (ist_reg & ~(hit_ist ? wdat[ppfm_pkg::IRQ_W-1:0] : '0)) | ev;
            if (hit_imsk)
                imsk_reg <= (imsk_reg & ~wmask[ppfm_pkg::IRQ_W-1:0]) |
                            wdat[ppfm_pkg::IRQ_W-1:0];
        end
    end
    assign irq = |(ist_reg & imsk_reg);

    // ========================================
    // input select fields: two per register, lanes 0 and 1
    always_ff @(posedge aclk) begin
        for (int k = 0; k < NIN; k++) begin
            if (!aresetn)
                insel_reg[k] <= ppfm_pkg::IN_SEL_RST;
            else if (hit_in[k/2] && s_axi_wstrb[k%2])
                insel_reg[k] <= wdat[(k % 2 == 1 ? ppfm_pkg::FLD_HI : ppfm_pkg::FLD_LO)
                                     +: ppfm_pkg::SEL_W]; // R09 R10 R11
        end
    end

    // input crossbar: a missing pin yields the idle level, not x
    always_ff @(posedge aclk) begin
        for (int j = 0; j < NIN; j++) begin
            if (!aresetn)
                periph_in[j] <= IDLE_LVL[j];
            else if (int'(insel_reg[j]) < NPI)
                periph_in[j] <= rp_st[insel_reg[j]]; // R09
            else
                periph_in[j] <= IDLE_LVL[j]; // R18
        end
    end

    logic sel_pin1;
    assign sel_pin1 = (int'(insel_reg[1]) < NPI) ? rp_st[insel_reg[1]] : 1'b0;
    in_route_a: assert property (int'(insel_reg[1]) < NPI |=>
        periph_in[1] == $past(sel_pin1)) // R09
        else $error("input not fed from selected pin");
    in_missing_a: assert property (int'(insel_reg[0]) >= NPI |=>
        periph_in[0] == IDLE_LVL[0]) // R18
        else $error("missing pin not held idle");

    // ========================================
    // output select fields, cleared to null at every reset
    always_ff @(posedge aclk) begin
        for (int k = 0; k < NRP; k++) begin
            if (!aresetn)
                outsel_reg[k] <= ppfm_pkg::OUT_SEL_RST; // R16
            else if (hit_out[k/2] && s_axi_wstrb[k%2])
                outsel_reg[k] <= wdat[(k % 2 == 1 ? ppfm_pkg::FLD_HI : ppfm_pkg::FLD_LO)
                                      +: ppfm_pkg::SEL_W]; // R12
        end
    end

    // output crossbar; the code is the peripheral's bit in periph_out
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NRP; i++) begin
            if (!aresetn) begin
                rp_pin_o[i] <= 1'b0;
                rp_pin_oe_n[i] <= 1'b1;
            end else if (outsel_reg[i] == ppfm_pkg::OUT_SEL_RST ||
                         code_bad(outsel_reg[i])) begin // R13 R17
                rp_pin_o[i] <= 1'b0;
                rp_pin_oe_n[i] <= 1'b1;
            end else begin
                rp_pin_o[i] <= periph_out[outsel_reg[i]]; // R12 R14 R15
                rp_pin_oe_n[i] <= 1'b0;
            end
        end
    end

    reset_null_a: assert property ($past(!aresetn) |-> &rp_pin_oe_n) // R16
        else $error("remappable pin driven after reset");
    null_code_a: assert property (outsel_reg[0] == ppfm_pkg::OC_NULL |=>
        rp_pin_oe_n[0] && !rp_pin_o[0]) // R13
        else $error("null code drives pin");
    bad_code_a: assert property (code_bad(outsel_reg[0]) |=> rp_pin_oe_n[0]) // R17
        else $error("unimplemented code drives pin");
    uart_code_a: assert property (outsel_reg[1] == ppfm_pkg::OC_UART1_TX |=>
        !rp_pin_oe_n[1] && rp_pin_o[1] == $past(periph_out[ppfm_pkg::OC_UART1_TX])) // R14
        else $error("uart transmit not routed");
    refclk_code_a: assert property (outsel_reg[0] == ppfm_pkg::OC_REF_CLOCK |=>
        !rp_pin_oe_n[0] && rp_pin_o[0] == $past(periph_out[ppfm_pkg::OC_REF_CLOCK])) // R15
        else $error("reference clock not routed");

    // ========================================
    // register read mux
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr == ppfm_pkg::OFF_ANALOG_SEL)
            rd_val[NPP-1:0] = ans_reg;
        else if (s_axi_araddr == ppfm_pkg::OFF_PIN_DIR)
            rd_val[NPP-1:0] = dir_reg;
        else if (s_axi_araddr == ppfm_pkg::OFF_PORT_LATCH)
            rd_val[NPP-1:0] = lat_reg;
        else if (s_axi_araddr == ppfm_pkg::OFF_PORT_IN)
            rd_val[NPP-1:0] = port_st & ~ans_reg; // R02 R04
        else if (s_axi_araddr == ppfm_pkg::OFF_PIN_CHANGE)
            rd_val[NPP-1:0] = pchg_reg;
        else if (s_axi_araddr == ppfm_pkg::OFF_CHANGE_STAT)
            rd_val[8:0] = chg_stat; // R06
        else if (s_axi_araddr == ppfm_pkg::OFF_IRQ_STAT)
            rd_val[ppfm_pkg::IRQ_W-1:0] = ist_reg;
        else if (s_axi_araddr == ppfm_pkg::OFF_IRQ_MASK)
            rd_val[ppfm_pkg::IRQ_W-1:0] = imsk_reg;
        else
            rd_ok = 1'b0;
        for (int k = 0; k < NINR; k++) begin
            if (s_axi_araddr == ppfm_pkg::OFF_IN_SEL + 12'(4 * k)) begin
                rd_ok = 1'b1;
                rd_val[ppfm_pkg::FLD_LO +: ppfm_pkg::SEL_W] = insel_reg[2*k];
                if (2 * k + 1 < NIN)
                    rd_val[ppfm_pkg::FLD_HI +: ppfm_pkg::SEL_W] =
                        insel_reg[(2 * k + 1 < NIN) ? 2 * k + 1 : 2 * k];
            end
        end
        for (int k = 0; k < NOR; k++) begin
            if (s_axi_araddr == ppfm_pkg::OFF_OUT_SEL + 12'(4 * k)) begin
                rd_ok = 1'b1;
                rd_val[ppfm_pkg::FLD_LO +: ppfm_pkg::SEL_W] = outsel_reg[2*k];
                rd_val[ppfm_pkg::FLD_HI +: ppfm_pkg::SEL_W] = outsel_reg[2*k+1];
            end
        end
    end

    // one read in flight; data returns the cycle after the address
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ppfm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? ppfm_pkg::RESP_OKAY : ppfm_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    analog_reads_low_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == ppfm_pkg::OFF_PORT_IN |=>
        (s_axi_rdata[NPP-1:0] & $past(ans_reg)) == '0) // R02
        else $error("analog pin read not low");

    // ========================================
    // scenario coverage
    write_done_c: cover property (wr_go ##1 s_axi_bvalid);
    pin_mapped_c: cover property (!rp_pin_oe_n[0]);
    change_flag_c: cover property (|chg_stat);
    irq_raised_c: cover property (irq);

endmodule // ppfm_top
`default_nettype wire
